// [shared/cso_pkg.sv]
package cso_pkg;
  // SDO abort codes carried in the abort data field.
  localparam logic [31:0] ABT_TOGGLE = 32'h0503_0000;
  localparam logic [31:0] ABT_CMD = 32'h0504_0001;
  localparam logic [31:0] ABT_ACCESS = 32'h0601_0000;
  localparam logic [31:0] ABT_RDONLY = 32'h0601_0002;
  localparam logic [31:0] ABT_NOOBJ = 32'h0602_0000;
  localparam logic [31:0] ABT_NOMAP = 32'h0604_0041;
  localparam logic [31:0] ABT_MAPLEN = 32'h0604_0042;
  localparam logic [31:0] ABT_LONG = 32'h0607_0012;
  localparam logic [31:0] ABT_SHORT = 32'h0607_0013;
  localparam logic [31:0] ABT_NOSUB = 32'h0609_0011;
  localparam logic [31:0] ABT_HIGH = 32'h0609_0031;
  localparam logic [31:0] ABT_LOW = 32'h0609_0032;
  localparam logic [31:0] ABT_GENERAL = 32'h0800_0000;
  localparam logic [31:0] ABT_STATE = 32'h0800_0022;
  // Dictionary indices handled here.
  localparam logic [15:0] IDX_ERRFLD = 16'h1003;
  localparam logic [15:0] IDX_RXCOM = 16'h1400;
  localparam logic [15:0] IDX_RXMAP = 16'h1600;
  localparam logic [15:0] IDX_TXCOM = 16'h1800;
  localparam logic [15:0] IDX_TXMAP = 16'h1A00;
  localparam logic [7:0] RXCOM_SUBS = 8'h02;
  // Transmission type limits.
  localparam logic [7:0] TT_SYNC_MAX = 8'hF0;
  localparam logic [7:0] TT_ASYNC_MIN = 8'hFE;
  localparam logic [7:0] TT_RESET = 8'hFF;
  // Mapping limit and COB-ID layout.
  localparam logic [6:0] MAP_MAX_BITS = 7'h40;
  localparam int COB_VALID_BIT = 31;
  localparam logic [10:0] COB_BASE0 = 11'h200;
  localparam logic [10:0] COB_STEP = 11'h100;
  localparam logic [31:0] COB_RESET = 32'h8000_0000;
  // APB register offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COB0 = 8'h20;
  localparam logic [7:0] REG_TT0 = 8'h40;
  localparam logic [7:0] REG_MAP0 = 8'h60;
  localparam int CTRL_RESTART = 0;

  // Network management states seen by the block.
  typedef enum logic [1:0] {
    NMT_STOPPED = 2'b00,
    NMT_PREOP = 2'b01,
    NMT_OPER = 2'b10
  } cso_nmt_type;

  // One expedited SDO request from the master.
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] data;
  } cso_sdo_req_type;

  // Attributes of the addressed object from the dictionary.
  typedef struct packed {
    logic exists;
    logic sub_exists;
    logic read_only;
    logic mappable;
    logic [2:0] size;
    logic [31:0] max_val;
    logic [31:0] min_val;
    logic fault;
  } cso_obj_info_type;

  // One received CAN frame.
  typedef struct packed {
    logic [10:0] id;
    logic [63:0] data;
  } cso_frame_type;
endpackage

// [core/cso_canopen_node.sv]
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// Functional notes
// [R1] Failed SDO access sends 32-bit abort code.
// [R2] Unchanged segment toggle aborts with 05030000.
// [R3] Unknown command byte aborts with 05040001.
// [R4] Complete access aborts with 06010000.
// [R5] Read-only write aborts, entry kept.
// [R6] Missing index aborts with 06020000.
// [R7] Non-mappable object mapping aborts 06040041.
// [R8] Mapping over eight bytes aborts 06040042.
// [R9] Too many data bytes abort 06070012.
// [R10] Too few data bytes abort 06070013.
// [R11] Missing subindex aborts with 06090011.
// [R12] Value over limit aborts 06090031.
// [R13] Value under limit aborts 06090032.
// [R14] Other failures abort with 08000000.
// [R15] PDO parameter writes refused when Operational.
// [R16] PDOs processed only when Operational.
// [R17] Eight mappings, at most 64 bits.
// [R18] RX parameters have subindices 0, 1, 2.
// [R19] First four IDs fixed; valid bit writable.
// [R20] New identifier used only after restart.
// [R21] Types 00h-F0h commit on next SYNC.
// [R22] Types FEh/FFh commit on arrival.
module cso_canopen_node (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Node context.
  input wire logic [6:0] node_id,
  input wire cso_pkg::cso_nmt_type nmt_state,
  input wire logic comm_restart,
  // SDO request and dictionary attributes.
  input wire logic sdo_valid,
  input wire cso_pkg::cso_sdo_req_type sdo_req,
  input wire cso_pkg::cso_obj_info_type obj_info,
  // SDO answer.
  output logic sdo_ok,
  output logic sdo_abort,
  output logic [31:0] abort_code,
  // Received frames and SYNC.
  input wire logic rx_valid,
  input wire cso_pkg::cso_frame_type rx_frame,
  input wire logic sync_pulse,
  // Committed PDO data towards the dictionary.
  output logic commit_valid,
  output logic [2:0] commit_map,
  output logic [63:0] commit_data
);
  import cso_pkg::*;

  logic [31:0] cob_q [8];       // Written COB-IDs, not yet in use.
  logic [31:0] act_q [8];       // COB-IDs the receiver matches.
  logic [7:0] tt_q [8];         // Transmission types.
  logic [6:0] map_bits_q [8];   // Mapped length in bits.
  logic [63:0] buf_q [8];       // Buffered PDO payloads.
  logic [7:0] pend_q;           // Waiting for SYNC.
  logic [7:0] ready_q;          // Waiting for the commit port.
  logic seg_q;                  // Segmented upload running.
  logic toggle_q;               // Expected toggle bit.
  logic [31:0] last_abort_q;    // Latest abort code for software.
  logic restart_q;              // Software restart pulse.

  // Decoded request fields.
  logic [2:0] ccs;
  logic is_write;
  logic [2:0] nbytes;
  logic [2:0] slot;
  logic pdo_par;
  logic rx_com;
  logic rx_map;
  logic [7:0] mlen;
  logic [7:0] msum;
  logic [31:0] code_d;
  logic fail_d;

  assign ccs = sdo_req.cmd[7:5];
  assign is_write = (ccs == 3'h1);
  // Expedited length is four minus the unused-byte count.
  assign nbytes = 3'h4 - {1'b0, sdo_req.cmd[3:2]};
  assign slot = sdo_req.index[2:0];
  assign pdo_par = (sdo_req.index[15:3] == IDX_RXCOM[15:3])
                || (sdo_req.index[15:3] == IDX_RXMAP[15:3])
                || (sdo_req.index[15:3] == IDX_TXCOM[15:3])
                || (sdo_req.index[15:3] == IDX_TXMAP[15:3]);
  assign rx_com = (sdo_req.index[15:3] == IDX_RXCOM[15:3]);
  assign rx_map = (sdo_req.index[15:3] == IDX_RXMAP[15:3]);
  assign mlen = sdo_req.data[7:0];
  assign msum = {1'b0, map_bits_q[slot]} + mlen;

  // Abort cause selection; earlier checks win over later ones.
  always_comb begin
    fail_d = 1'b1;
    code_d = ABT_GENERAL;
    // [R3] command byte check
    if (!(ccs inside {3'h1, 3'h2, 3'h3, 3'h4})) begin
      code_d = ABT_CMD;
    // [R2] toggle bit check
    end else if (ccs == 3'h3 && (!seg_q || sdo_req.cmd[4] != toggle_q)) begin
      code_d = ABT_TOGGLE;
    end else if (ccs == 3'h3 || ccs == 3'h4) begin
      fail_d = 1'b0;
    // [R4] complete access refused
    end else if (sdo_req.cmd[4]) begin
      code_d = ABT_ACCESS;
    // [R6] index lookup
    end else if (!obj_info.exists) begin
      code_d = ABT_NOOBJ;
    // [R11] subindex lookup; RX records stop at subindex 2
    end else if (!obj_info.sub_exists || (rx_com && sdo_req.sub > RXCOM_SUBS)) begin
      code_d = ABT_NOSUB;
    end else if (!is_write) begin
      fail_d = obj_info.fault;
    // [R15] PDO parameters locked while Operational
    end else if (pdo_par && nmt_state == NMT_OPER) begin
      code_d = ABT_STATE;
    // [R5] read-only entry
    end else if (obj_info.read_only) begin
      code_d = ABT_RDONLY;
    // [R9] too many bytes
    end else if (sdo_req.cmd[0] && nbytes > obj_info.size) begin
      code_d = ABT_LONG;
    // [R10] too few bytes
    end else if (sdo_req.cmd[0] && nbytes < obj_info.size) begin
      code_d = ABT_SHORT;
    // [R7] mappable check
    end else if (rx_map && sdo_req.sub != 8'h00 && !obj_info.mappable) begin
      code_d = ABT_NOMAP;
    // [R8] mapping length limit
    end else if (rx_map && sdo_req.sub != 8'h00 && msum > {1'b0, MAP_MAX_BITS}) begin
      code_d = ABT_MAPLEN;
    // [R12] upper limit, error counter accepts only zero
    end else if ((sdo_req.index == IDX_ERRFLD && sdo_req.sub == 8'h00
                  && sdo_req.data != 32'h0) || sdo_req.data > obj_info.max_val) begin
      code_d = ABT_HIGH;
    // [R13] lower limit
    end else if (sdo_req.data < obj_info.min_val) begin
      code_d = ABT_LOW;
    end else begin
      // [R14] anything else the dictionary flags
      fail_d = obj_info.fault;
    end
  end

  // SDO answer; the abort carries the selected code.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdo_ok <= 1'b0;
      sdo_abort <= 1'b0;
      abort_code <= 32'h0000_0000;
      last_abort_q <= 32'h0000_0000;
    end else begin
      // A received abort from the master is not confirmed.
      sdo_ok <= sdo_valid && !fail_d && ccs != 3'h4;
      // [R1] abort with error code
      sdo_abort <= sdo_valid && fail_d;
      if (sdo_valid && fail_d) begin
        abort_code <= code_d;
        last_abort_q <= code_d;
      end
    end
  end

  // Segmented upload tracking; toggle restarts at 0 per transfer.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seg_q <= 1'b0;
      toggle_q <= 1'b0;
    end else if (sdo_valid) begin
      if (ccs == 3'h2 && !fail_d) begin
        seg_q <= 1'b1;
        toggle_q <= 1'b0;
      // [R2] expect alternation
      end else if (ccs == 3'h3 && !fail_d) begin
        toggle_q <= !toggle_q;
      end else begin
        seg_q <= 1'b0;
      end
    end
  end

  // RX PDO parameters written through accepted SDO downloads.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        cob_q[i] <= COB_RESET;
        tt_q[i] <= TT_RESET;
        map_bits_q[i] <= 7'h00;
      end
    end else if (sdo_valid && is_write && !fail_d) begin
      // [R18] subindex 1 identifier, 2 transmission type
      if (rx_com && sdo_req.sub == 8'h01) begin
        // [R19] fixed IDs take only the valid bit
        if (!slot[2]) begin
          cob_q[slot][COB_VALID_BIT] <= sdo_req.data[COB_VALID_BIT];
        end else begin
          cob_q[slot] <= sdo_req.data;
        end
      end
      if (rx_com && sdo_req.sub == 8'h02) begin
        tt_q[slot] <= sdo_req.data[7:0];
      end
      // [R17] track mapped length; zero count clears it
      if (rx_map && sdo_req.sub == 8'h00 && sdo_req.data == 32'h0) begin
        map_bits_q[slot] <= 7'h00;
      end else if (rx_map && sdo_req.sub != 8'h00) begin
        map_bits_q[slot] <= msum[6:0];
      end
    end
  end

  // Identifiers in use change only on a restart of communication.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        act_q[i] <= COB_RESET;
      end
    // [R20] apply identifiers on restart
    end else if (comm_restart || restart_q) begin
      for (int i = 0; i < 8; i++) begin
        act_q[i] <= cob_q[i];
        // [R19] base plus node ID for the first four
        if (i < 4) begin
          act_q[i][10:0] <= COB_BASE0 + COB_STEP * 11'(i) + {4'h0, node_id};
          act_q[i][30:11] <= 20'h0_0000;
        end
      end
    end
  end

  // Receive path: match, buffer and schedule commits.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_q <= 8'h00;
      ready_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        buf_q[i] <= 64'h0;
      end
    end else begin
      // Drain one ready mapping per cycle, lowest first.
      for (int i = 7; i >= 0; i--) begin
        if (ready_q[i] && (ready_q & ((8'h01 << i) - 8'h01)) == 8'h00) begin
          ready_q[i] <= 1'b0;
        end
      end
      // [R21] SYNC releases buffered data
      // Merge with bits still waiting, so an unserved arrival is never lost.
      if (sync_pulse && nmt_state == NMT_OPER) begin
        for (int i = 0; i < 8; i++) begin
          if (pend_q[i]) begin
            ready_q[i] <= 1'b1;
          end
        end
        pend_q <= 8'h00;
      end
      // [R16] only Operational receives PDOs
      if (rx_valid && nmt_state == NMT_OPER) begin
        for (int i = 0; i < 8; i++) begin
          if (!act_q[i][COB_VALID_BIT] && act_q[i][10:0] == rx_frame.id) begin
            // [R21] synchronous types wait for SYNC
            if (tt_q[i] <= TT_SYNC_MAX) begin
              buf_q[i] <= rx_frame.data;
              pend_q[i] <= 1'b1;
            // [R22] asynchronous types commit now; set beats drain
            end else if (tt_q[i] >= TT_ASYNC_MIN) begin
              buf_q[i] <= rx_frame.data;
              ready_q[i] <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Commit port presents the lowest ready mapping.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      commit_valid <= 1'b0;
      commit_map <= 3'h0;
      commit_data <= 64'h0;
    end else begin
      commit_valid <= |ready_q;
      for (int i = 7; i >= 0; i--) begin
        if (ready_q[i]) begin
          commit_map <= 3'(i);
          commit_data <= buf_q[i];
        end
      end
    end
  end

  // APB slave with no wait state; read data comes from a flop loaded in the setup cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      restart_q <= 1'b0;
    end else begin
      pready <= psel && !penable;
      restart_q <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel && !penable) begin
        if (paddr == REG_CTRL) begin
          prdata <= 32'h0;
        end else if (paddr == REG_STATUS) begin
          prdata <= last_abort_q;
        end else if (paddr[7:5] == REG_COB0[7:5] && paddr[1:0] == 2'b00) begin
          prdata <= act_q[paddr[4:2]];
        end else if (paddr[7:5] == REG_TT0[7:5] && paddr[1:0] == 2'b00) begin
          prdata <= {24'h0, tt_q[paddr[4:2]]};
        end else if (paddr[7:5] == REG_MAP0[7:5] && paddr[1:0] == 2'b00) begin
          prdata <= {25'h0, map_bits_q[paddr[4:2]]};
        end else begin
          // Unmapped addresses answer with an error.
          pslverr <= 1'b1;
        end
        // Only the control word is writable; the rest reads back state.
        if (pwrite && paddr != REG_CTRL) begin
          pslverr <= 1'b1;
        end
      end
      if (psel && penable && pready && pwrite && paddr == REG_CTRL) begin
        restart_q <= pwdata[CTRL_RESTART];
      end
      if (psel && penable && pready) begin
        pready <= 1'b0;
      end
    end
  end
endmodule

// [testbench/cso_node_sva.sv]
`timescale 1ns/1ns
module cso_node_sva (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Register bus handshake.
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // SDO side.
  input wire cso_pkg::cso_nmt_type nmt_state,
  input wire logic sdo_valid,
  input wire cso_pkg::cso_sdo_req_type sdo_req,
  input wire cso_pkg::cso_obj_info_type obj_info,
  input wire logic sdo_ok,
  input wire logic sdo_abort,
  input wire logic [31:0] abort_code,
  input wire logic commit_valid
);
  import cso_pkg::*;
  // Every check runs on the one clock and is silent during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Command class, plain init access and PDO parameter target of the offered request.
  logic [2:0] ccs;
  logic init_acc;
  logic pdo_par;
  assign ccs = sdo_req.cmd[7:5];
  assign init_acc = sdo_valid && (ccs == 3'h1 || ccs == 3'h2) && !sdo_req.cmd[4];
  // A too-high subindex of an RX record is refused earlier, so it is left out here.
  assign pdo_par = (sdo_req.index[15:8] inside {8'h14, 8'h16, 8'h18, 8'h1A})
    && sdo_req.index[7:3] == 5'h00 && !(sdo_req.index[15:8] == 8'h14 && sdo_req.sub > RXCOM_SUBS);

  AST_ONE_ANSWER: assert property (sdo_valid && ccs != 3'h4 |=> sdo_ok != sdo_abort)
    else $error("SDO request without exactly one answer");
  AST_NO_STRAY: assert property ((sdo_ok || sdo_abort) |-> $past(sdo_valid))
    else $error("SDO answer without a request");
  AST_CODE_HELD: assert property (!sdo_abort |-> $stable(abort_code))
    else $error("Abort code moved without an abort");
  AST_CMD_UNKNOWN: assert property (sdo_valid && ccs inside {3'h5, 3'h6, 3'h7}
    |=> sdo_abort && abort_code == ABT_CMD)
    else $error("Unknown command not aborted");
  AST_COMPLETE: assert property (sdo_valid && (ccs == 3'h1 || ccs == 3'h2) && sdo_req.cmd[4]
    |=> sdo_abort && abort_code == ABT_ACCESS)
    else $error("Complete access not aborted");
  AST_NOOBJ: assert property (init_acc && !obj_info.exists |=> abort_code == ABT_NOOBJ)
    else $error("Missing object not aborted");
  AST_NOSUB: assert property (init_acc && obj_info.exists && !obj_info.sub_exists
    |=> sdo_abort && abort_code == ABT_NOSUB)
    else $error("Missing subindex not aborted");
  AST_OPER_LOCK: assert property (init_acc && ccs == 3'h1 && obj_info.exists
    && obj_info.sub_exists && nmt_state == NMT_OPER && pdo_par |=> abort_code == ABT_STATE)
    else $error("PDO parameter write accepted while operational");
  AST_READY_TIME: assert property (psel && !penable |=> pready)
    else $error("Bus answer not in the access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("Bus ready longer than one cycle");

  // Main scenarios reached.
  COV_ABORT: cover property (sdo_valid ##1 sdo_abort);
  COV_COMMIT: cover property (commit_valid);
  COV_BUS: cover property (psel && penable && pready);
endmodule

bind cso_canopen_node cso_node_sva i_sva (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pready(pready), .nmt_state(nmt_state), .sdo_valid(sdo_valid),
  .sdo_req(sdo_req), .obj_info(obj_info), .sdo_ok(sdo_ok), .sdo_abort(sdo_abort),
  .abort_code(abort_code), .commit_valid(commit_valid));

// [testbench/cso_master_model.sv]
`timescale 1ns/1ns
module cso_master_model (
  // Clock.
  input wire logic clk,
  // Network events.
  output logic comm_restart,
  output logic sync_pulse,
  // SDO requests.
  output logic sdo_valid,
  output cso_pkg::cso_sdo_req_type sdo_req,
  // PDO frames.
  output logic rx_valid,
  output cso_pkg::cso_frame_type rx_frame
);
  import cso_pkg::*;
  // Idle bus from time zero.
  initial begin
    comm_restart = 1'h0;
    sync_pulse = 1'h0;
    sdo_valid = 1'h0;
    sdo_req = '0;
    rx_valid = 1'h0;
    rx_frame = '0;
  end
  // One request for one cycle; the content is scrambled afterwards so stale data never helps.
  task send_sdo(input cso_sdo_req_type r);
    @(posedge clk);
    sdo_valid <= 1'h1;
    sdo_req <= r;
    @(posedge clk);
    sdo_valid <= 1'h0;
    sdo_req <= ~r;
  endtask
  // One frame for one cycle, scrambled afterwards.
  task send_pdo(input cso_frame_type f);
    @(posedge clk);
    rx_valid <= 1'h1;
    rx_frame <= f;
    @(posedge clk);
    rx_valid <= 1'h0;
    rx_frame <= ~f;
  endtask
  // A single restart of communication.
  task send_restart;
    @(posedge clk);
    comm_restart <= 1'h1;
    @(posedge clk);
    comm_restart <= 1'h0;
  endtask
  // A single SYNC message.
  task send_sync;
    @(posedge clk);
    sync_pulse <= 1'h1;
    @(posedge clk);
    sync_pulse <= 1'h0;
  endtask
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ns
module testbench;
  import cso_pkg::*;
  // Default dictionary answer: a plain writable 32-bit mappable object.
  localparam cso_obj_info_type OI_DEF = {4'hD, 3'h4, 32'hFFFF_FFFF, 32'h0, 1'h0};
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, comm_restart, sync_pulse;
  logic sdo_valid, sdo_ok, sdo_abort, rx_valid, commit_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, abort_code;
  logic [6:0] node_id;
  logic [2:0] commit_map;
  logic [63:0] commit_data;
  cso_nmt_type nmt_state;
  cso_sdo_req_type sdo_req;
  cso_obj_info_type obj_info, oi;
  cso_frame_type rx_frame;
  int miscompares, cmp_count, cycles;

  cso_canopen_node i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .node_id(node_id), .nmt_state(nmt_state), .comm_restart(comm_restart),
    .sdo_valid(sdo_valid), .sdo_req(sdo_req), .obj_info(obj_info), .sdo_ok(sdo_ok),
    .sdo_abort(sdo_abort), .abort_code(abort_code), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .sync_pulse(sync_pulse), .commit_valid(commit_valid), .commit_map(commit_map),
    .commit_data(commit_data));
  cso_master_model i_master (.clk(clk), .comm_restart(comm_restart), .sync_pulse(sync_pulse),
    .sdo_valid(sdo_valid), .sdo_req(sdo_req), .rx_valid(rx_valid), .rx_frame(rx_frame));

  // Compare and count.
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Verdict and end of run.
  task results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One APB transfer, held until ready is seen at a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
           output logic er);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Read one register and compare.
  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] rd;
    logic er;
    apb(1'h0, a, 32'h0, rd, er);
    chk(rd, exp, msg);
  endtask
  // Offer one SDO request with the current object attributes; zero expects acceptance.
  task sdo(input logic [7:0] c, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
           input logic [31:0] exp);
    @(posedge clk);
    obj_info <= oi;
    i_master.send_sdo({c, i, s, d});
    @(negedge clk);
    chk(sdo_ok ? 32'h0 : (sdo_abort ? abort_code : 32'hDEAD_BEEF), exp, "sdo answer");
  endtask
  // Expect one commit within a few cycles, or none when none is set.
  task commit(input logic none, input logic [2:0] m, input logic [63:0] d);
    int n;
    n = 0;
    while (commit_valid !== 1'h1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, commit_valid}, {31'h0, !none}, "commit presence");
    if (!none) begin
      chk({commit_map, commit_data[60:32]}, {m, d[60:32]}, "commit map and high data");
      chk(commit_data[31:0], d[31:0], "commit low data");
      chk({29'h0, commit_data[63:61]}, {29'h0, d[63:61]}, "commit top data");
    end
    @(negedge clk);
  endtask

  // Reset contents and bus refusals.
  task t_regs;
    logic [31:0] rd;
    logic er;
    for (int n = 0; n < 8; n++) begin
      rdchk(REG_COB0 + 8'(4 * n), COB_RESET, "cob reset");
      rdchk(REG_TT0 + 8'(4 * n), {24'h0, TT_RESET}, "type reset");
    end
    apb(1'h0, 8'hFC, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1, "unmapped read");
    apb(1'h1, REG_STATUS, 32'h1, rd, er);
    chk({31'h0, er}, 32'h1, "status write");
  endtask
  // Each abort cause apart from the mapping and state ones, with the value just past each limit.
  task t_sdo;
    oi = OI_DEF;
    sdo(8'hE0, 16'h2000, 8'h00, 32'h0, ABT_CMD);
    sdo(8'h50, 16'h2000, 8'h00, 32'h0, ABT_ACCESS);
    sdo(8'h23, IDX_RXCOM, 8'h03, 32'h0, ABT_NOSUB);
    sdo(8'h23, IDX_ERRFLD, 8'h00, 32'h1, ABT_HIGH);
    sdo(8'h23, IDX_ERRFLD, 8'h00, 32'h0, 32'h0);
    oi.exists = 1'h0;
    sdo(8'h40, 16'h2000, 8'h00, 32'h0, ABT_NOOBJ);
    oi = OI_DEF;
    oi.sub_exists = 1'h0;
    sdo(8'h40, 16'h2000, 8'h05, 32'h0, ABT_NOSUB);
    oi = OI_DEF;
    oi.size = 3'h1;
    sdo(8'h23, 16'h2000, 8'h00, 32'h5, ABT_LONG);
    oi.read_only = 1'h1;
    sdo(8'h2F, IDX_RXCOM, 8'h02, 32'hFE, ABT_RDONLY);
    rdchk(REG_TT0, 32'hFF, "read-only entry kept");
    oi = OI_DEF;
    sdo(8'h2F, 16'h2000, 8'h00, 32'h5, ABT_SHORT);
    oi.max_val = 32'h10;
    oi.min_val = 32'h5;
    sdo(8'h23, 16'h2000, 8'h00, 32'h11, ABT_HIGH);
    sdo(8'h23, 16'h2000, 8'h00, 32'h4, ABT_LOW);
    sdo(8'h23, 16'h2000, 8'h00, 32'h5, 32'h0);
    oi = OI_DEF;
    oi.fault = 1'h1;
    sdo(8'h40, 16'h2000, 8'h00, 32'h0, ABT_GENERAL);
    oi = OI_DEF;
    sdo(8'h40, 16'h2000, 8'h00, 32'h0, 32'h0);
    sdo(8'h60, 16'h2000, 8'h00, 32'h0, 32'h0);
    sdo(8'h70, 16'h2000, 8'h00, 32'h0, 32'h0);
    sdo(8'h70, 16'h2000, 8'h00, 32'h0, ABT_TOGGLE);
  endtask
  // Mapping content: non-mappable object and the eight-byte ceiling.
  task t_map;
    oi = OI_DEF;
    oi.mappable = 1'h0;
    sdo(8'h23, IDX_RXMAP, 8'h01, 32'h6040_0010, ABT_NOMAP);
    oi.mappable = 1'h1;
    sdo(8'h23, IDX_RXMAP, 8'h01, 32'h607A_0020, 32'h0);
    sdo(8'h23, IDX_RXMAP, 8'h02, 32'h6081_0020, 32'h0);
    sdo(8'h23, IDX_RXMAP, 8'h03, 32'h6040_0008, ABT_MAPLEN);
    rdchk(REG_MAP0, 32'h40, "mapped bits");
  endtask
  // Identifiers, restart, state gating and the two commit timings.
  task t_pdo;
    logic [31:0] rd;
    logic er;
    oi = OI_DEF;
    sdo(8'h23, IDX_RXCOM, 8'h01, 32'h0, 32'h0);
    sdo(8'h23, IDX_RXCOM + 16'h1, 8'h01, 32'h0, 32'h0);
    sdo(8'h23, IDX_RXCOM + 16'h7, 8'h01, 32'h1FF, 32'h0);
    oi.size = 3'h1;
    sdo(8'h2F, IDX_RXCOM, 8'h02, 32'h1, 32'h0);
    sdo(8'h2F, IDX_RXCOM + 16'h1, 8'h02, 32'hFE, 32'h0);
    rdchk(REG_COB0, COB_RESET, "old id kept");
    apb(1'h1, REG_CTRL, 32'h1, rd, er);
    rdchk(REG_COB0, 32'h205, "fixed id 1");
    rdchk(REG_COB0 + 8'h4, 32'h305, "fixed id 2");
    rdchk(REG_COB0 + 8'h1C, 32'h1FF, "free id 8");
    oi = OI_DEF;
    sdo(8'h23, IDX_RXCOM + 16'h7, 8'h01, 32'h1FE, 32'h0);
    rdchk(REG_COB0 + 8'h1C, 32'h1FF, "id 8 before restart");
    i_master.send_restart;
    rdchk(REG_COB0 + 8'h1C, 32'h1FE, "id 8 after restart");
    i_master.send_pdo({11'h305, 64'h1122_3344_5566_7788});
    commit(1'h1, 3'h0, 64'h0);
    @(posedge clk);
    nmt_state <= NMT_OPER;
    sdo(8'h2F, IDX_TXMAP, 8'h00, 32'h0, ABT_STATE);
    i_master.send_pdo({11'h205, 64'hA5A5_0000_FFFF_1234});
    commit(1'h1, 3'h0, 64'h0);
    i_master.send_sync;
    commit(1'h0, 3'h0, 64'hA5A5_0000_FFFF_1234);
    i_master.send_pdo({11'h305, 64'h0102_0304_0506_0708});
    commit(1'h0, 3'h1, 64'h0102_0304_0506_0708);
    i_master.send_pdo({11'h1FE, 64'hFEDC_BA98_7654_3210});
    commit(1'h0, 3'h7, 64'hFEDC_BA98_7654_3210);
  endtask

  // Free-running 10 MHz clock.
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Hang guard well above the few hundred cycles the run needs.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      results;
    end
  end
  // Main sequence.
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h0, 32'h0};
    {miscompares, cmp_count, cycles} = '0;
    node_id = 7'h05;
    nmt_state = NMT_PREOP;
    obj_info = OI_DEF;
    oi = OI_DEF;
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    t_regs;
    t_sdo;
    t_map;
    t_pdo;
    results;
  end
endmodule
